// file: rtl/imu_cfg_if.sv
// register port between the configuring processor and the sensor
`timescale 1ns/1ps
`default_nettype none
interface imu_cfg_if;
  logic       req;
  logic       we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       ack;
  modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
  modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface
`default_nettype wire

// file: rtl/imu_host_end.sv
// configuring processor end: waits for boot, sequences mode changes safely
`timescale 1ns/1ps
`default_nettype none
module imu_host_end
  import imu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  imu_cfg_if.host         bus,
  input  wire logic       cfg_valid,
  output logic            cfg_ready,
  input  wire logic [2:0] accel_mode_in,
  input  wire logic [3:0] accel_rate_in,
  input  wire logic [2:0] gyro_mode_in,
  input  wire logic [3:0] gyro_rate_in,
  input  wire logic [1:0] set_in,
  input  wire logic       charge_req,
  input  wire logic       activity_req,
  input  wire logic       motion_req,
  output logic            charge_en,
  output logic            activity_en,
  output logic            motion_en,
  output logic            precise_on,
  output logic            booted
);
  typedef enum logic [2:0] {
    S_POLL = 3'h0, S_IDLE = 3'h1, S_AOFF = 3'h2, S_GOFF = 3'h3,
    S_SET  = 3'h4, S_ACC  = 3'h5, S_GYR  = 3'h6
  } hstate_t;

  hstate_t    st_ff, nxt_st;
  logic [6:0] acc_ff, nxt_acc, gyr_ff, nxt_gyr;
  logic [1:0] set_ff, nxt_set;
  logic       ha_ff, nxt_ha, tgt_ha_ff, nxt_tgt_ha;
  logic       want_ha;

  // ==========================================================================
  // sequencer
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_acc    = acc_ff;
    nxt_gyr    = gyr_ff;
    nxt_set    = set_ff;
    nxt_ha     = ha_ff;
    nxt_tgt_ha = tgt_ha_ff;
    want_ha    = accel_mode_in == MODE_HA || gyro_mode_in == MODE_HA; // RULE14
    bus.req    = st_ff != S_IDLE;
    bus.we     = st_ff != S_POLL;
    bus.addr   = STATUS_ADDR;
    bus.wdata  = 8'h00;
    case (st_ff)
      S_POLL:
      begin
        if (bus.ack && bus.rdata[0])
          nxt_st = S_IDLE;
      end
      S_IDLE:
      begin
        if (cfg_valid)
        begin
          nxt_acc    = {want_ha ? MODE_HA : accel_mode_in, accel_rate_in}; // RULE14 RULE3
          nxt_gyr    = {want_ha ? MODE_HA : gyro_mode_in, gyro_rate_in}; // RULE14 RULE3
          nxt_set    = set_in;
          nxt_tgt_ha = want_ha;
          nxt_st     = (want_ha != ha_ff) ? S_AOFF : S_ACC;
        end
      end
      S_AOFF:
      begin
        bus.addr  = ACCEL_CTRL_ADDR;
        bus.wdata = {1'b0, acc_ff[6:4], RATE_OFF}; // RULE16
        if (bus.ack)
          nxt_st = S_GOFF;
      end
      S_GOFF:
      begin
        bus.addr  = GYRO_CTRL_ADDR;
        bus.wdata = {1'b0, gyr_ff[6:4], RATE_OFF}; // RULE16
        if (bus.ack)
          nxt_st = S_SET;
      end
      S_SET:
      begin
        bus.addr  = PRECISE_ADDR;
        bus.wdata = {6'h00, set_ff};
        if (bus.ack)
        begin
          nxt_ha = tgt_ha_ff;
          nxt_st = S_ACC;
        end
      end
      S_ACC:
      begin
        bus.addr  = ACCEL_CTRL_ADDR;
        bus.wdata = {1'b0, acc_ff};
        if (bus.ack)
          nxt_st = S_GYR;
      end
      S_GYR:
      begin
        bus.addr  = GYRO_CTRL_ADDR;
        bus.wdata = {1'b0, gyr_ff};
        if (bus.ack)
          nxt_st = S_IDLE;
      end
      default:
        nxt_st = S_POLL;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff     <= S_POLL;
      acc_ff    <= CTRL_RESET;
      gyr_ff    <= CTRL_RESET;
      set_ff    <= SET_RESET;
      ha_ff     <= 1'b0;
      tgt_ha_ff <= 1'b0;
    end
    else
    begin
      st_ff     <= nxt_st;
      acc_ff    <= nxt_acc;
      gyr_ff    <= nxt_gyr;
      set_ff    <= nxt_set;
      ha_ff     <= nxt_ha;
      tgt_ha_ff <= nxt_tgt_ha;
    end
  end

  // ==========================================================================
  // user side
  assign cfg_ready   = st_ff == S_IDLE;
  assign booted      = st_ff != S_POLL;
  assign precise_on  = ha_ff;
  assign charge_en   = charge_req & ~ha_ff & ~tgt_ha_ff; // RULE17
  assign activity_en = activity_req & ~ha_ff & ~tgt_ha_ff; // RULE17
  assign motion_en   = motion_req;
endmodule
`default_nettype wire

// file: rtl/imu_pkg.sv
// shared constants, codes and decode functions for the sensor rate/power logic
package imu_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned BOOT_MS        = 10;
  localparam int unsigned BOOT_CYCLES    = CLK_HZ / 1000 * BOOT_MS;
  localparam int unsigned BASE_HZ_NOM    = 7680;
  localparam int unsigned BASE_HZ_SET1   = 8000;
  localparam int unsigned BASE_HZ_SET2   = 6400;
  localparam logic [12:0] BASE_DIV_NOM   = 13'(CLK_HZ / BASE_HZ_NOM);
  localparam logic [12:0] BASE_DIV_SET1  = 13'(CLK_HZ / BASE_HZ_SET1);
  localparam logic [12:0] BASE_DIV_SET2  = 13'(CLK_HZ / BASE_HZ_SET2);

  // ==========================================================================
  // register map
  localparam logic [7:0] ACCEL_CTRL_ADDR = 8'h10;
  localparam logic [7:0] GYRO_CTRL_ADDR  = 8'h11;
  localparam logic [7:0] PRECISE_ADDR    = 8'h12;
  localparam logic [7:0] STATUS_ADDR     = 8'h13;
  localparam int unsigned RATE_LSB       = 0;
  localparam int unsigned MODE_LSB       = 4;
  localparam int unsigned SET_LSB        = 0;
  localparam logic [6:0] CTRL_RESET      = 7'h00;
  localparam logic [1:0] SET_RESET       = 2'h0;

  // ==========================================================================
  // mode and rate codes
  localparam logic [2:0] MODE_HP    = 3'h0;
  localparam logic [2:0] MODE_HA    = 3'h1;
  localparam logic [2:0] MODE_TRIG  = 3'h3;
  localparam logic [2:0] MODE_LP1   = 3'h4;
  localparam logic [2:0] MODE_LP2   = 3'h5;
  localparam logic [2:0] MODE_LP3   = 3'h6;
  localparam logic [2:0] MODE_NORM  = 3'h7;
  localparam logic [2:0] GMODE_SLEEP = 3'h4;
  localparam logic [2:0] GMODE_LP    = 3'h5;
  localparam logic [3:0] RATE_OFF    = 4'h0;
  localparam logic [3:0] RATE_1P875  = 4'h1;
  localparam logic [3:0] RATE_7P5    = 4'h2;
  localparam logic [3:0] RATE_240    = 4'h7;
  localparam logic [3:0] RATE_1920   = 4'hA;
  localparam logic [3:0] RATE_TOP    = 4'hC;

  // low-power family, per channel
  function automatic logic is_lp(input logic acc, input logic [2:0] m);
    is_lp = acc ? (m == MODE_LP1 || m == MODE_LP2 || m == MODE_LP3) : (m == GMODE_LP);
  endfunction

  // log2 of measurements averaged per sample
  function automatic logic [1:0] avg_exp(input logic acc, input logic [2:0] m);
    case ({acc, m})
      {1'b1, MODE_LP1}: avg_exp = 2'h1;
      {1'b1, MODE_LP2}: avg_exp = 2'h2;
      {1'b1, MODE_LP3}: avg_exp = 2'h3;
      default:          avg_exp = 2'h0;
    endcase
  endfunction

  // rate code legal for this mode; anything else leaves the channel idle
  function automatic logic rate_ok(input logic acc, input logic [2:0] m, input logic [3:0] r);
    if (is_lp(acc, m))
      rate_ok = (r >= RATE_7P5 || (acc && r == RATE_1P875)) && r <= RATE_240
                && !(acc && r == RATE_7P5);
    else if (m == MODE_HA)
      rate_ok = r > RATE_7P5 && r <= RATE_TOP;
    else if (m == MODE_HP || m == MODE_TRIG)
      rate_ok = r >= RATE_7P5 && r <= RATE_TOP;
    else if (acc && m == MODE_NORM)
      rate_ok = r >= RATE_7P5 && r <= RATE_1920;
    else
      rate_ok = 1'b0;
  endfunction

  // base ticks per sample minus one; all rates are the base over a power of two
  function automatic logic [11:0] div_mask(input logic [3:0] r);
    case (r)
      RATE_1P875: div_mask = 12'hFFF;
      RATE_7P5:   div_mask = 12'h3FF;
      default:    div_mask = 12'((12'h001 << (4'hC - r)) - 12'h001);
    endcase
  endfunction

endpackage

// file: rtl/imu_sensor_end.sv
// sensor end: boot, configuration registers, rate timing and channel sampling
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: boot of at most 10 ms first
// RULE2: boot ends with both channels powered down
// RULE3: only the three channel combinations are used
// RULE4: accel timing derived from gyro, integer multiples
// RULE5: power-down keeps port alive, holds last data
// RULE6: low-power modes average 2, 4, 8
// RULE7: low-power duty-cycles, no anti-alias, max 240 Hz
// RULE8: normal mode continuous, anti-alias, max 1920 Hz
// RULE9: high-performance continuous, anti-alias, max 7680 Hz
// RULE10: decode the 3-bit accel mode field
// RULE11: rate code zero forces power-down
// RULE12: decode the 4-bit rate field
// RULE13: precise set picks nominal, 8000 or 6400 family
// RULE14: precise mode used on both or neither
// RULE15: stabilisation timing ignores precise mode
// RULE16: both rates zero before toggling precise mode
// RULE17: no charge or activity sensing in precise
// RULE18: triggered mode follows external reference
// RULE19: gyro sleep keeps drive, chain off
// RULE20: illegal rate for mode means no samples
// RULE21: new settings applied at sample boundary
module imu_sensor_end
  import imu_pkg::*;
#(
  parameter int unsigned BOOT_LEN = BOOT_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  imu_cfg_if.dev           bus,
  input  wire logic        ext_ref,
  input  wire logic [15:0] accel_raw,
  input  wire logic [15:0] gyro_raw,
  output logic      [15:0] accel_data,
  output logic      [15:0] gyro_data,
  output logic             accel_stb,
  output logic             gyro_stb,
  output logic             accel_chain_on,
  output logic             gyro_chain_on,
  output logic             accel_aa_en,
  output logic             gyro_drive_on,
  output logic             stab_tick,
  output logic             boot_done
);

  // ==========================================================================
  // boot and register file
  logic [22:0] boot_cnt_ff, nxt_boot_cnt;
  logic        boot_done_ff, nxt_boot_done;
  logic [6:0]  accel_ctrl_ff, nxt_accel_ctrl;
  logic [6:0]  gyro_ctrl_ff, nxt_gyro_ctrl;
  logic [1:0]  set_ff, nxt_set;
  logic        ack_ff, nxt_ack;
  logic [7:0]  rdata_ff, nxt_rdata;
  logic        take;
  logic [1:0]  act;

  assign take = bus.req & ~ack_ff;

  always_comb
  begin
    nxt_boot_cnt   = boot_cnt_ff;
    nxt_boot_done  = boot_done_ff;
    nxt_accel_ctrl = accel_ctrl_ff;
    nxt_gyro_ctrl  = gyro_ctrl_ff;
    nxt_set        = set_ff;
    nxt_ack        = take;
    nxt_rdata      = rdata_ff;
    if (!boot_done_ff)
    begin
      if (boot_cnt_ff == 23'(BOOT_LEN - 1))
        nxt_boot_done = 1'b1; // RULE1
      else
        nxt_boot_cnt = boot_cnt_ff + 23'h1; // RULE1
    end
    if (take && bus.we) // RULE5
    begin
      case (bus.addr)
        ACCEL_CTRL_ADDR: nxt_accel_ctrl = bus.wdata[6:0];
        GYRO_CTRL_ADDR:  nxt_gyro_ctrl  = bus.wdata[6:0];
        PRECISE_ADDR:    nxt_set        = bus.wdata[SET_LSB +: 2];
        default:         nxt_set        = nxt_set;
      endcase
    end
    if (take && !bus.we)
    begin
      case (bus.addr)
        ACCEL_CTRL_ADDR: nxt_rdata = {1'b0, accel_ctrl_ff};
        GYRO_CTRL_ADDR:  nxt_rdata = {1'b0, gyro_ctrl_ff};
        PRECISE_ADDR:    nxt_rdata = {6'h00, set_ff};
        STATUS_ADDR:     nxt_rdata = {4'h0, gyro_drive_on, act[1], act[0], boot_done_ff};
        default:         nxt_rdata = 8'h00;
      endcase
    end
    if (!boot_done_ff && nxt_boot_done)
    begin
      nxt_accel_ctrl[RATE_LSB +: 4] = RATE_OFF; // RULE2
      nxt_gyro_ctrl[RATE_LSB +: 4]  = RATE_OFF; // RULE2
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      boot_cnt_ff   <= 23'h0;
      boot_done_ff  <= 1'b0;
      accel_ctrl_ff <= CTRL_RESET;
      gyro_ctrl_ff  <= CTRL_RESET;
      set_ff        <= SET_RESET;
      ack_ff        <= 1'b0;
      rdata_ff      <= 8'h00;
    end
    else
    begin
      boot_cnt_ff   <= nxt_boot_cnt;
      boot_done_ff  <= nxt_boot_done;
      accel_ctrl_ff <= nxt_accel_ctrl;
      gyro_ctrl_ff  <= nxt_gyro_ctrl;
      set_ff        <= nxt_set;
      ack_ff        <= nxt_ack;
      rdata_ff      <= nxt_rdata;
    end
  end

  assign bus.ack   = ack_ff;
  assign bus.rdata = rdata_ff;
  assign boot_done = boot_done_ff;

  // ==========================================================================
  // shared sample timing: one base, one octave counter for both channels
  logic [12:0] base_cnt_ff, nxt_base_cnt;
  logic [12:0] nom_cnt_ff, nxt_nom_cnt;
  logic [11:0] oct_ff, nxt_oct;
  logic [12:0] base_div;
  logic        base_tick, ref_rise;

  always_comb
  begin
    case (set_ff)
      2'h1:    base_div = BASE_DIV_SET1; // RULE13
      2'h2:    base_div = BASE_DIV_SET2; // RULE13
      default: base_div = BASE_DIV_NOM;
    endcase
    // a shorter base after a set change must not run the count round
    base_tick    = base_cnt_ff >= base_div - 13'h1;
    nxt_base_cnt = base_tick ? 13'h0 : base_cnt_ff + 13'h1;
    nxt_oct      = base_tick ? oct_ff + 12'h1 : oct_ff; // RULE4
    stab_tick    = nom_cnt_ff == BASE_DIV_NOM - 13'h1; // RULE15
    nxt_nom_cnt  = stab_tick ? 13'h0 : nom_cnt_ff + 13'h1;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      base_cnt_ff <= 13'h0;
      nom_cnt_ff  <= 13'h0;
      oct_ff      <= 12'h0;
    end
    else
    begin
      base_cnt_ff <= nxt_base_cnt;
      nom_cnt_ff  <= nxt_nom_cnt;
      oct_ff      <= nxt_oct;
    end
  end

  ref_sync u_ref_sync
  (
    .clk    (clk),
    .arst_n (arst_n),
    .pin    (ext_ref),
    .rise   (ref_rise)
  );

  // ==========================================================================
  // per-channel sampling: index 0 acceleration, 1 angular rate
  logic [15:0] raw [2];
  logic [15:0] data [2];
  logic [6:0]  ctrl [2];
  logic [1:0]  stb, chain, aa, sleep_on;

  assign raw[0]  = accel_raw;
  assign raw[1]  = gyro_raw;
  assign ctrl[0] = accel_ctrl_ff;
  assign ctrl[1] = gyro_ctrl_ff;

  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    localparam logic ACC = (i == 0);
    logic [2:0]  mode_ff, nxt_mode;
    logic [3:0]  rate_ff, nxt_rate;
    logic [3:0]  burst_ff, nxt_burst;
    logic [18:0] sum_ff, nxt_sum;
    logic [15:0] data_ff, nxt_data;
    logic        stb_ff, nxt_stb;
    logic        tick, lp;
    logic [1:0]  n;
    logic [18:0] total;

    always_comb
    begin
      act[i]      = boot_done_ff && rate_ok(ACC, mode_ff, rate_ff); // RULE11 RULE20 RULE10 RULE12
      lp          = is_lp(ACC, mode_ff); // RULE7
      n           = avg_exp(ACC, mode_ff); // RULE6
      sleep_on[i] = !ACC && boot_done_ff && mode_ff == GMODE_SLEEP && rate_ff != RATE_OFF;
      tick        = act[i] && ((mode_ff == MODE_TRIG) ? ref_rise // RULE18
                    : base_tick && (oct_ff & div_mask(rate_ff)) == 12'h0); // RULE4
      total       = sum_ff + {3'h0, raw[i]};
      nxt_mode    = mode_ff;
      nxt_rate    = rate_ff;
      nxt_burst   = burst_ff;
      nxt_sum     = sum_ff;
      nxt_data    = data_ff; // RULE5
      nxt_stb     = 1'b0;
      if (!act[i] || tick)
      begin
        nxt_mode = ctrl[i][MODE_LSB +: 3]; // RULE21
        nxt_rate = ctrl[i][RATE_LSB +: 4]; // RULE21
      end
      if (tick && lp)
      begin
        nxt_burst = 4'(4'h1 << n); // RULE6
        nxt_sum   = 19'h0;
      end
      else if (tick)
      begin
        nxt_data = raw[i]; // RULE8 RULE9
        nxt_stb  = 1'b1;
      end
      else if (burst_ff != 4'h0)
      begin
        nxt_burst = burst_ff - 4'h1;
        nxt_sum   = total;
        if (burst_ff == 4'h1)
        begin
          nxt_data = 16'(total >> n); // RULE6
          nxt_stb  = 1'b1;
        end
      end
      chain[i] = lp ? (burst_ff != 4'h0) : act[i]; // RULE7 RULE8 RULE9 RULE19
      aa[i]    = act[i] && !lp; // RULE7 RULE8 RULE9
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        mode_ff  <= MODE_HP;
        rate_ff  <= RATE_OFF;
        burst_ff <= 4'h0;
        sum_ff   <= 19'h0;
        data_ff  <= 16'h0000;
        stb_ff   <= 1'b0;
      end
      else
      begin
        mode_ff  <= nxt_mode;
        rate_ff  <= nxt_rate;
        burst_ff <= nxt_burst;
        sum_ff   <= nxt_sum;
        data_ff  <= nxt_data;
        stb_ff   <= nxt_stb;
      end
    end

    assign data[i] = data_ff;
    assign stb[i]  = stb_ff;
  end

  assign accel_data     = data[0];
  assign gyro_data      = data[1];
  assign accel_stb      = stb[0];
  assign gyro_stb       = stb[1];
  assign accel_chain_on = chain[0];
  assign gyro_chain_on  = chain[1];
  assign accel_aa_en    = aa[0];
  assign gyro_drive_on  = act[1] | sleep_on[1]; // RULE19

endmodule
`default_nettype wire

// file: rtl/ref_sync.sv
// three-stage synchroniser with rising-edge pulse for the external reference
`timescale 1ns/1ps
`default_nettype none
module ref_sync
(
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic pin,
  output logic      rise
);
  logic s1_ff, s2_ff, s3_ff, lvl_ff;
  logic nxt_lvl;

  always_comb
  begin
    nxt_lvl = (s2_ff == s3_ff) ? s3_ff : lvl_ff;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_ff  <= 1'b0;
      s2_ff  <= 1'b0;
      s3_ff  <= 1'b0;
      lvl_ff <= 1'b0;
    end
    else
    begin
      s1_ff  <= pin;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      lvl_ff <= nxt_lvl;
    end
  end

  assign rise = nxt_lvl & ~lvl_ff;
endmodule
`default_nettype wire

// file: verification/imu_cfg_sva.sv
// assertions on the configuration port shared by host and sensor ends
`timescale 1ns/1ps
`default_nettype none
module imu_cfg_sva
  import imu_pkg::*;
#(
  parameter int unsigned BOOT_LEN = BOOT_CYCLES
)
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       req,
  input wire logic       we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       ack
);
  // ==========================================================================
  // shadow of written fields, cycles since reset, boot seen by host
  logic [3:0]  acc_rate_ff;
  logic [3:0]  nxt_acc_rate;
  logic [3:0]  gyr_rate_ff;
  logic [3:0]  nxt_gyr_rate;
  logic [2:0]  acc_mode_ff;
  logic [2:0]  nxt_acc_mode;
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  logic        boot_ff;
  logic        nxt_boot;
  logic        wr_ack;
  logic        rd_ack;

  assign wr_ack = ack && we;
  assign rd_ack = ack && !we;

  always_comb
  begin
    nxt_acc_rate = acc_rate_ff;
    nxt_acc_mode = acc_mode_ff;
    nxt_gyr_rate = gyr_rate_ff;
    nxt_cnt      = (cnt_ff < BOOT_LEN + 2) ? cnt_ff + 1 : cnt_ff;
    nxt_boot     = boot_ff || (rd_ack && addr == STATUS_ADDR && rdata[0]);
    if (wr_ack && addr == ACCEL_CTRL_ADDR)
    begin
      nxt_acc_rate = wdata[3:0];
      nxt_acc_mode = wdata[6:4];
    end
    if (wr_ack && addr == GYRO_CTRL_ADDR)
      nxt_gyr_rate = wdata[3:0];
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      acc_rate_ff <= RATE_OFF;
      acc_mode_ff <= MODE_HP;
      gyr_rate_ff <= RATE_OFF;
      cnt_ff      <= 32'h0000_0000;
      boot_ff     <= 1'b0;
    end
    else
    begin
      acc_rate_ff <= nxt_acc_rate;
      acc_mode_ff <= nxt_acc_mode;
      gyr_rate_ff <= nxt_gyr_rate;
      cnt_ff      <= nxt_cnt;
      boot_ff     <= nxt_boot;
    end
  end

  // ==========================================================================
  // properties
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_answer: assert property (req && !ack |=> ack)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without a request");
  a_req_hold: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
    else $error("request changed before ack");
  a_rdata_hold: assert property (!ack |-> $stable(rdata))
    else $error("read data changed outside ack");
  a_zero_first: assert property (wr_ack && addr == PRECISE_ADDR |->
    acc_rate_ff == RATE_OFF && gyr_rate_ff == RATE_OFF)
    else $error("precise set written with a channel running");
  a_precise_pair: assert property (wr_ack && addr == GYRO_CTRL_ADDR && wdata[3:0] != RATE_OFF
    |-> (wdata[6:4] == MODE_HA) == (acc_mode_ff == MODE_HA))
    else $error("precise mode on one channel only");
  a_boot_status: assert property (rd_ack && addr == STATUS_ADDR && rdata[0]
    |-> cnt_ff >= BOOT_LEN)
    else $error("boot reported done too early");
  a_write_booted: assert property (wr_ack |-> boot_ff)
    else $error("write before boot seen");

  c_precise: cover property (wr_ack && addr == PRECISE_ADDR);
  c_pair: cover property (wr_ack && addr == GYRO_CTRL_ADDR && wdata[6:4] == MODE_HA);
  c_boot: cover property (rd_ack && addr == STATUS_ADDR && rdata[0]);
endmodule
`default_nettype wire

// file: verification/test_imu_power_mode_rate_select.sv
// self-checking bench joining host and sensor ends over the configuration port
`timescale 1ns/1ps
`default_nettype none
module test_imu_power_mode_rate_select
  import imu_pkg::*;
;
  localparam int BOOT  = 20;
  localparam int LIMIT = 99000;
  localparam int NOM   = CLK_HZ / BASE_HZ_NOM;
  logic clk = 1'b0, arst_n = 1'b0, cfg_valid = 1'b0, ext_ref = 1'b0;
  logic [2:0] accel_mode_in = 3'h0, gyro_mode_in = 3'h0;
  logic [3:0] accel_rate_in = 4'h0, gyro_rate_in = 4'h0;
  logic [1:0] set_in = 2'h0;
  logic charge_req = 1'b1, activity_req = 1'b1, motion_req = 1'b1;
  logic [15:0] accel_raw = 16'h0000, gyro_raw = 16'h0000, old_a, old_g;
  logic [15:0] accel_data, gyro_data;
  logic accel_stb, gyro_stb, accel_chain_on, gyro_chain_on, accel_aa_en, gyro_drive_on;
  logic stab_tick, boot_done, cfg_ready, charge_en, activity_en, motion_en, precise_on, booted;
  logic [6:0] bad [6];
  int num_errors = 0, tests_run = 0, cycles = 0, n, k, seed, s, q[$];

  // ==========================================================================
  // ends, port and checker
  imu_cfg_if bus ();
  imu_sensor_end #(.BOOT_LEN(BOOT)) u_imu_sensor_end (.clk, .arst_n, .bus(bus.dev), .ext_ref,
    .accel_raw, .gyro_raw, .accel_data, .gyro_data, .accel_stb, .gyro_stb, .accel_chain_on,
    .gyro_chain_on, .accel_aa_en, .gyro_drive_on, .stab_tick, .boot_done);
  imu_host_end u_imu_host_end (.clk, .arst_n, .bus(bus.host), .cfg_valid, .cfg_ready,
    .accel_mode_in, .accel_rate_in, .gyro_mode_in, .gyro_rate_in, .set_in, .charge_req,
    .activity_req, .motion_req, .charge_en, .activity_en, .motion_en, .precise_on, .booted);
  imu_cfg_sva #(.BOOT_LEN(BOOT)) u_imu_cfg_sva (.clk, .arst_n, .req(bus.req), .we(bus.we),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack));

  always #12.5 clk = ~clk;

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ==========================================================================
  // helpers
  task automatic tally_and_finish();
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic compare(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function automatic logic pick(input int s);
    pick = s == 0 ? accel_stb : s == 1 ? gyro_stb : stab_tick;
  endfunction

  task automatic wait_for(input int s, input int lim, output int c);
    c = 0;
    do
    begin
      @(negedge clk);
      c++;
    end
    while (pick(s) !== 1'b1 && c < lim);
  endtask

  // model: base period times a power of two
  task automatic gap(input int s, input int base, input logic [3:0] code);
    int c;
    wait_for(s, 20000, c);
    wait_for(s, 20000, c);
    compare("sample_gap", c, base << (12 - code));
  endtask

  task automatic count(input int s, input int len, output int c);
    c = 0;
    repeat (len)
    begin
      @(negedge clk);
      c += (pick(s) === 1'b1);
    end
  endtask

  task automatic cfg(input logic [2:0] am, input logic [3:0] ar, input logic [2:0] gm,
                     input logic [3:0] gr, input logic [1:0] s);
    {accel_mode_in, accel_rate_in, gyro_mode_in, gyro_rate_in, set_in} = {am, ar, gm, gr, s};
    cfg_valid = 1'b1;
    @(negedge clk);
    cfg_valid = 1'b0;
    compare("ready_busy", cfg_ready, 1'b0);
    repeat (14) @(negedge clk);
    compare("ready_back", cfg_ready, 1'b1);
  endtask

  task automatic wait_off(input int lim);
    int c;
    c = 0;
    while ((accel_chain_on | gyro_chain_on | gyro_drive_on) !== 1'b0 && c < lim)
    begin
      @(negedge clk);
      c++;
    end
  endtask

  // ==========================================================================
  // scenarios
  initial
  begin
    seed = 32'h75e9_9f62;
    bad = '{{MODE_HP, RATE_1P875}, {MODE_NORM, 4'hB}, {MODE_LP1, 4'h8},
            {MODE_LP3, RATE_7P5}, {3'h2, 4'h5}, {MODE_HP, 4'hD}};
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    n = 0;
    while (boot_done !== 1'b1 && n < 1000)
    begin
      @(negedge clk);
      n++;
    end
    compare("boot_len", n, BOOT);
    compare("ready_in_boot", cfg_ready, 1'b0);
    n = 0;
    while (cfg_ready !== 1'b1 && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    compare("booted", booted, 1'b1);
    compare("off_after_boot", {accel_chain_on, gyro_chain_on, gyro_drive_on}, 3'h0);
    for (int i = 0; i < 6; i++)
    begin
      cfg(bad[i][6:4], bad[i][3:0], MODE_HP, RATE_OFF, SET_RESET);
      compare("bad_combo", {accel_chain_on, accel_aa_en}, 2'h0);
    end
    accel_raw = 16'($random(seed));
    gyro_raw = 16'($random(seed));
    cfg(MODE_HP, RATE_TOP, GMODE_SLEEP, RATE_TOP, SET_RESET);
    compare("sleep_drive", {gyro_drive_on, gyro_chain_on}, 2'h2);
    compare("hp_chain", {accel_chain_on, accel_aa_en}, 2'h3);
    gap(0, NOM, RATE_TOP);
    compare("accel_data", accel_data, accel_raw);
    cfg(MODE_HP, RATE_TOP, MODE_HP, RATE_TOP, SET_RESET);
    gap(1, NOM, RATE_TOP);
    compare("gyro_data", gyro_data, gyro_raw);
    cfg(MODE_HP, RATE_OFF, MODE_HP, RATE_OFF, SET_RESET);
    wait_off(6000);
    compare("pd_chain", {accel_chain_on, gyro_chain_on, gyro_drive_on}, 3'h0);
    {old_a, old_g} = {accel_raw, gyro_raw};
    accel_raw = ~old_a;
    gyro_raw = ~old_g;
    count(0, 100, k);
    compare("pd_stb", k, 0);
    compare("pd_hold", {accel_data, gyro_data}, {old_a, old_g});
    compare("pd_sense", {charge_en, activity_en}, 2'h3);
    cfg(MODE_HA, RATE_TOP, MODE_HP, RATE_TOP, 2'h1);
    compare("precise", precise_on, 1'b1);
    compare("precise_sense", {charge_en, activity_en, motion_en}, 3'h1);
    gap(1, CLK_HZ / BASE_HZ_SET1, RATE_TOP);
    gap(2, NOM, RATE_TOP);
    cfg(MODE_HP, RATE_OFF, MODE_HP, RATE_OFF, SET_RESET);
    compare("precise_off", precise_on, 1'b0);
    wait_off(6000);
    cfg(MODE_HA, RATE_TOP, MODE_HA, RATE_OFF, 2'h2);
    gap(0, CLK_HZ / BASE_HZ_SET2, RATE_TOP);
    cfg(MODE_TRIG, RATE_TOP, MODE_HP, RATE_OFF, SET_RESET);
    wait_for(0, 7000, n);
    compare("trig_chain", {accel_chain_on, accel_aa_en, precise_on}, 3'h6);
    for (int i = 0; i < 3; i++)
    begin
      ext_ref = 1'b1;
      wait_for(0, 10, n);
      compare("trig_follow", n < 10, 1'b1);
      ext_ref = 1'b0;
      count(0, 30, k);
      compare("trig_quiet", k, 0);
    end
    // reset zeroes the octave count, so a slow tick is near
    for (int m = 0; m < 3; m++)
    begin
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      n = 0;
      while (cfg_ready !== 1'b1 && n < 100)
      begin
        @(negedge clk);
        n++;
      end
      cfg(3'(MODE_LP1 + m), RATE_240, MODE_HP, RATE_OFF, SET_RESET);
      compare("lp_idle", {accel_chain_on, accel_aa_en}, 2'h0);
      q = {};
      k = 0;
      while (accel_stb !== 1'b1 && k < 6000)
      begin
        @(negedge clk);
        accel_raw = 16'($random(seed));
        if (accel_chain_on === 1'b1)
          q.push_back(accel_raw);
        k++;
      end
      s = q.sum();
      compare("lp_count", q.size(), 2 << m);
      compare("lp_avg", accel_data, s >> (m + 1));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
